// ===== logic/rcl_regs.svh
// Timing counts, addresses and strap level codes for the redriver config loader
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

// Core clock rate
`define RCL_CLK_MHZ       250
`define RCL_CLK_KHZ       (`RCL_CLK_MHZ * 1000)
// Serial clock rate generated as bus master
`define RCL_SCL_KHZ       303
// One quarter of a serial clock period, in core cycles
`define RCL_QUARTER_CYC   (`RCL_CLK_KHZ / (`RCL_SCL_KHZ * 4))
// Bus free time before a start, as a least time
`define RCL_TBUF_NS       1300
`define RCL_TBUF_CYC      ((`RCL_TBUF_NS * `RCL_CLK_MHZ + 999) / 1000)
// Longest configuration load time
`define RCL_LOAD_TIME_US  7500
`define RCL_LOAD_CYC      (`RCL_LOAD_TIME_US * `RCL_CLK_MHZ)
// Memory device address and first word read
`define RCL_EE_ADDR       7'h50
`define RCL_EE_WORD       8'h00
// Number of configuration bytes
`define RCL_CFG_BYTES     16
`define RCL_CFG_LAST      4'hF
// Strap level codes
`define RCL_LVL_L0        2'h0
`define RCL_LVL_L1        2'h1
// Core cycles after reset before straps are captured
`define RCL_CAP_WAIT      2'h3

`endif

// ===== logic/rcl_pkg.sv
// Types shared by the redriver config loader
package rcl_pkg;

	typedef enum logic [1:0] {
		RCL_MODE_PIN    = 2'h0,
		RCL_MODE_MASTER = 2'h1,
		RCL_MODE_SLAVE  = 2'h2
	} rcl_mode_type;

	typedef enum logic [2:0] {
		RCL_ST_IDLE  = 3'h0,
		RCL_ST_START = 3'h1,
		RCL_ST_BIT   = 3'h2,
		RCL_ST_STOP  = 3'h3,
		RCL_ST_DONE  = 3'h4
	} rcl_state_type;

	// Four-level strap codes, one 2-bit level each
	typedef struct packed {
		logic [1:0] eq1_0;
		logic [1:0] eq0_0;
		logic [1:0] eq1_1;
		logic [1:0] eq0_1;
		logic [1:0] gain1;
		logic [1:0] gain0;
		logic [1:0] rx_det;
		logic [1:0] mode;
	} rcl_strap_type;

	typedef logic [15:0][7:0] rcl_cfg_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} rcl_hwr_type;

endpackage

// ===== logic/rcl_loader.sv
// Redriver configuration loader: straps, memory read as master, host writes
`include "rcl_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Pin mode: settings come only from straps, no serial traffic.
// - Master mode: act as bus master and read settings from memory.
// - After a successful memory read, drive done output low.
// - Host register writes are accepted before, during and after the load.
// - Load completes within 7.5 ms of the load request going low.
// - Mode level L1 selects master mode with serial clock near 303 kHz.
// - Mode level L0 selects pin mode, equalization and gain from straps.
// - Straps sampled once at power-up; mode strap followed continuously.
module rcl_loader #(
	parameter int LOAD_TIME_CYC = `RCL_LOAD_CYC
) (
	input  wire logic                  ref_clk_in,        // Core clock
	input  wire logic                  resetn_in,         // Async reset
	input  wire logic                  link_clk_in,       // Host side clock
	input  wire rcl_pkg::rcl_strap_type strap_in,         // Strap levels
	input  wire logic                  read_en_n_in,      // Load request
	output logic                       done_n_out,        // Load complete
	input  wire logic                  scl_in,            // Clock pin level
	output logic                       scl_out,           // Clock drive
	output logic                       scl_oe_out,        // Clock enable
	input  wire logic                  sda_in,            // Data pin level
	output logic                       sda_out,           // Data drive
	output logic                       sda_oe_out,        // Data enable
	input  wire logic                  host_wr_valid_in,  // Host write
	input  wire rcl_pkg::rcl_hwr_type  host_wr_in,        // Addr and data
	output logic                       host_wr_ready_out, // Write taken
	output rcl_pkg::rcl_cfg_type       cfg_out,           // Settings
	output rcl_pkg::rcl_mode_type      mode_out           // Active mode
);

	////////////////////////////////////////////////////////////////////
	// State types

	typedef struct packed {
		rcl_pkg::rcl_state_type st;
		rcl_pkg::rcl_mode_type  mode;
		logic [8:0]             qcnt;
		logic [1:0]             q;
		logic [3:0]             bitn;
		logic [7:0]             shreg;
		logic [1:0]             seg;
		logic [3:0]             idx;
		logic                   rd;
		logic                   fail;
		logic                   scl_oe;
		logic                   sda_oe;
		logic                   done;
		logic [8:0]             idle_cnt;
		rcl_pkg::rcl_strap_type strap_m;
		rcl_pkg::rcl_strap_type strap_s;
		rcl_pkg::rcl_strap_type strap_cap;
		logic                   cap_done;
		logic [1:0]             cap_cnt;
		logic                   scl_m;
		logic                   scl_s;
		logic                   sda_m;
		logic                   sda_s;
		logic                   ren_m;
		logic                   ren_s;
		logic                   req_m;
		logic                   req_s;
		logic                   ack_tog;
		rcl_pkg::rcl_cfg_type   cfg;
	} rcl_core_type;

	typedef struct packed {
		logic                   req_tog;
		rcl_pkg::rcl_hwr_type   hold;
		logic                   ack_m;
		logic                   ack_s;
	} rcl_link_type;

	rcl_core_type s_r;
	rcl_core_type s_nxt;
	rcl_link_type lk_r;
	rcl_link_type lk_nxt;

	////////////////////////////////////////////////////////////////////
	// Functions

	function automatic rcl_pkg::rcl_mode_type mode_of(
		input logic [1:0] lvl
	);
		if (lvl == `RCL_LVL_L0)
			return rcl_pkg::RCL_MODE_PIN;
		if (lvl == `RCL_LVL_L1)
			return rcl_pkg::RCL_MODE_MASTER;
		return rcl_pkg::RCL_MODE_SLAVE;
	endfunction

	function automatic rcl_pkg::rcl_cfg_type pin_cfg(
		input rcl_pkg::rcl_strap_type sp
	);
		rcl_pkg::rcl_cfg_type c;
		c = '0;
		c[0] = {sp.eq1_0, sp.eq0_0, sp.eq1_1, sp.eq0_1};
		c[1] = {sp.gain1, sp.gain0, sp.rx_det, 2'h0};
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Link side: host write capture, toggle handshake toward the core

	always_comb begin
		lk_nxt = lk_r;
		lk_nxt.ack_m = s_r.ack_tog;
		lk_nxt.ack_s = lk_r.ack_m;
		if (host_wr_valid_in && host_wr_ready_out) begin
			lk_nxt.hold = host_wr_in;
			lk_nxt.req_tog = ~lk_r.req_tog;
		end
	end

	always_ff @(posedge link_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			lk_r <= '0;
		else
			lk_r <= lk_nxt;
	end

	assign host_wr_ready_out = (lk_r.ack_s == lk_r.req_tog);

	////////////////////////////////////////////////////////////////////
	// Core logic

	logic tick;
	logic new_wr;

	assign tick   = (s_r.qcnt == 9'h000);
	assign new_wr = (s_r.req_s != s_r.ack_tog);

	always_comb begin
		s_nxt = s_r;
		s_nxt.strap_m = strap_in;
		s_nxt.strap_s = s_r.strap_m;
		s_nxt.scl_m   = scl_in;
		s_nxt.scl_s   = s_r.scl_m;
		s_nxt.sda_m   = sda_in;
		s_nxt.sda_s   = s_r.sda_m;
		s_nxt.ren_m   = read_en_n_in;
		s_nxt.ren_s   = s_r.ren_m;
		s_nxt.req_m   = lk_r.req_tog;
		s_nxt.req_s   = s_r.req_m;
		// Only the mode strap is followed after power-up
		s_nxt.mode    = mode_of(s_r.strap_s.mode);
		if (!s_r.cap_done) begin
			s_nxt.cap_cnt = s_r.cap_cnt + 2'h1;
			if (s_r.cap_cnt == `RCL_CAP_WAIT) begin
				s_nxt.cap_done  = 1'b1;
				s_nxt.strap_cap = s_r.strap_s;
			end
		end
		if (s_r.st != rcl_pkg::RCL_ST_IDLE &&
		    s_r.st != rcl_pkg::RCL_ST_DONE) begin
			s_nxt.qcnt = tick ? 9'(`RCL_QUARTER_CYC - 1)
			                  : s_r.qcnt - 9'h001;
			if (tick)
				s_nxt.q = s_r.q + 2'h1;
		end
		unique case (s_r.st)
		rcl_pkg::RCL_ST_IDLE: begin
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.q      = 2'h0;
			s_nxt.qcnt   = 9'(`RCL_QUARTER_CYC - 1);
			if (s_r.scl_s && s_r.sda_s &&
			    s_r.idle_cnt != 9'(`RCL_TBUF_CYC))
				s_nxt.idle_cnt = s_r.idle_cnt + 9'h001;
			else if (!(s_r.scl_s && s_r.sda_s))
				s_nxt.idle_cnt = 9'h000;
			// Waits for a free bus so a host master is not cut off
			if (s_r.mode == rcl_pkg::RCL_MODE_MASTER &&
			    !s_r.done && !s_r.ren_s && s_r.cap_done &&
			    s_r.idle_cnt == 9'(`RCL_TBUF_CYC)) begin
				s_nxt.st    = rcl_pkg::RCL_ST_START;
				s_nxt.seg   = 2'h0;
				s_nxt.shreg = {`RCL_EE_ADDR, 1'b0};
				s_nxt.rd    = 1'b0;
				s_nxt.fail  = 1'b0;
			end
		end
		rcl_pkg::RCL_ST_START: begin
			// Same sequence serves first and repeated start
			if (tick) begin
				unique case (s_r.q)
				2'h0: s_nxt.sda_oe = 1'b0;
				2'h1: s_nxt.scl_oe = 1'b0;
				2'h2: s_nxt.sda_oe = 1'b1;
				2'h3: begin
					s_nxt.scl_oe = 1'b1;
					s_nxt.bitn   = 4'h0;
					s_nxt.st     = rcl_pkg::RCL_ST_BIT;
				end
				endcase
			end
		end
		rcl_pkg::RCL_ST_BIT: begin
			if (tick) begin
				unique case (s_r.q)
				2'h0: begin
					if (s_r.bitn != 4'h8)
						s_nxt.sda_oe = !s_r.rd && !s_r.shreg[7];
					else
						s_nxt.sda_oe = s_r.rd &&
						               (s_r.idx != `RCL_CFG_LAST);
				end
				2'h1: s_nxt.scl_oe = 1'b0;
				2'h2: begin
					if (!s_r.scl_s) begin
						// Clock held low by another party
						s_nxt.q = 2'h2;
					end else if (s_r.bitn != 4'h8) begin
						if (s_r.rd)
							s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s};
						else if (!s_r.sda_oe && !s_r.sda_s) begin
							// Lost arbitration: let go, retry later
							s_nxt.st       = rcl_pkg::RCL_ST_IDLE;
							s_nxt.scl_oe   = 1'b0;
							s_nxt.sda_oe   = 1'b0;
							s_nxt.idle_cnt = 9'h000;
						end
					end else if (!s_r.rd && s_r.sda_s)
						s_nxt.fail = 1'b1;
				end
				2'h3: begin
					s_nxt.scl_oe = 1'b1;
					s_nxt.bitn   = s_r.bitn + 4'h1;
					if (s_r.bitn != 4'h8) begin
						if (!s_r.rd)
							s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
					end else if (s_r.fail)
						s_nxt.st = rcl_pkg::RCL_ST_STOP;
					else begin
						s_nxt.bitn = 4'h0;
						unique case (s_r.seg)
						2'h0: begin
							s_nxt.seg   = 2'h1;
							s_nxt.shreg = `RCL_EE_WORD;
						end
						2'h1: begin
							s_nxt.seg   = 2'h2;
							s_nxt.shreg = {`RCL_EE_ADDR, 1'b1};
							s_nxt.st    = rcl_pkg::RCL_ST_START;
						end
						2'h2: begin
							s_nxt.seg = 2'h3;
							s_nxt.rd  = 1'b1;
							s_nxt.idx = 4'h0;
						end
						2'h3: begin
							s_nxt.cfg[s_r.idx] = s_r.shreg;
							if (s_r.idx == `RCL_CFG_LAST)
								s_nxt.st = rcl_pkg::RCL_ST_STOP;
							else
								s_nxt.idx = s_r.idx + 4'h1;
						end
						endcase
					end
				end
				endcase
			end
		end
		rcl_pkg::RCL_ST_STOP: begin
			if (tick) begin
				unique case (s_r.q)
				2'h0: s_nxt.sda_oe = 1'b1;
				2'h1: s_nxt.scl_oe = 1'b0;
				2'h2: s_nxt.sda_oe = 1'b0;
				2'h3: begin
					// A refused byte retries the whole read
					s_nxt.st   = s_r.fail ? rcl_pkg::RCL_ST_IDLE
					                      : rcl_pkg::RCL_ST_DONE;
					s_nxt.done = !s_r.fail;
					s_nxt.fail     = 1'b0;
					s_nxt.rd       = 1'b0;
					s_nxt.idle_cnt = 9'h000;
				end
				endcase
			end
		end
		rcl_pkg::RCL_ST_DONE: begin
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end
		default: s_nxt.st = rcl_pkg::RCL_ST_IDLE;
		endcase
		// Host writes land in any engine state; in pin mode the strap settings below replace them
		if (new_wr) begin
			s_nxt.ack_tog = s_r.req_s;
			s_nxt.cfg[lk_r.hold.addr] = lk_r.hold.data;
		end
		// Leaving master mode aborts the load and re-arms it
		if (s_r.mode != rcl_pkg::RCL_MODE_MASTER) begin
			s_nxt.st     = rcl_pkg::RCL_ST_IDLE;
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.done   = 1'b0;
			s_nxt.rd     = 1'b0;
		end
		if (s_r.mode == rcl_pkg::RCL_MODE_PIN)
			s_nxt.cfg = s_r.cap_done ? pin_cfg(s_r.strap_cap)
			                         : '0;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign done_n_out = ~s_r.done;
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = s_r.scl_oe;
	assign sda_oe_out = s_r.sda_oe;
	assign cfg_out    = s_r.cfg;
	assign mode_out   = s_r.mode;

	////////////////////////////////////////////////////////////////////
	// Checks

	logic [21:0] ld_cnt_r;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			ld_cnt_r <= 22'h000000;
		else if (s_r.mode == rcl_pkg::RCL_MODE_MASTER && !s_r.done &&
		         !s_r.ren_s && ld_cnt_r != 22'h3FFFFF)
			ld_cnt_r <= ld_cnt_r + 22'h000001;
		else if (s_r.done || s_r.ren_s)
			ld_cnt_r <= 22'h000000;
	end

	property p_pin_quiet;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(s_r.mode == rcl_pkg::RCL_MODE_PIN) |=> !scl_oe_out && !sda_oe_out;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet)
		else $error("bus driven in pin mode");

	property p_master_only;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		$rose(scl_oe_out) |-> $past(s_r.mode) == rcl_pkg::RCL_MODE_MASTER;
	endproperty
	a_master_only: assert property (p_master_only)
		else $error("bus activity outside master mode");

	property p_done_low;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(s_r.st == rcl_pkg::RCL_ST_STOP && tick && s_r.q == 2'h3 &&
		 !s_r.fail && s_r.mode == rcl_pkg::RCL_MODE_MASTER)
		|=> !done_n_out ##1 !done_n_out;
	endproperty
	a_done_low: assert property (p_done_low)
		else $error("done not driven low after load");

	property p_host_ack;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		new_wr |=> (s_r.ack_tog == $past(s_r.req_s)) &&
		           (s_r.cfg[$past(lk_r.hold.addr)] == $past(lk_r.hold.data) ||
		            s_r.mode == rcl_pkg::RCL_MODE_PIN ||
		            $past(s_r.mode) == rcl_pkg::RCL_MODE_PIN);
	endproperty
	a_host_ack: assert property (p_host_ack)
		else $error("host write not applied");

	property p_load_time;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		ld_cnt_r <= 22'(LOAD_TIME_CYC);
	endproperty
	a_load_time: assert property (p_load_time)
		else $error("load took too long");

	property p_scl_high;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		($fell(scl_oe_out) && s_r.mode == rcl_pkg::RCL_MODE_MASTER)
		|-> (!scl_oe_out)[*8];
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("serial clock high phase too short");

	property p_strap_hold;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		s_r.cap_done |=> $stable(s_r.strap_cap) && s_r.cap_done;
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("straps resampled after power-up");

	property p_start_req;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(s_r.st == rcl_pkg::RCL_ST_IDLE ##1 s_r.st != rcl_pkg::RCL_ST_IDLE)
		|-> !$past(s_r.ren_s) && done_n_out;
	endproperty
	a_start_req: assert property (p_start_req)
		else $error("load started without request");

endmodule

// ===== sim/rcl_eeprom_model.sv
// Behavioural configuration memory on the open-drain serial bus
module rcl_eeprom_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	input  wire logic scl_in,     // Clock wire level
	input  wire logic sda_in,     // Data wire level
	output logic      sda_oe_out  // High pulls data low
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] mem [16];
	logic [7:0] sh;
	logic [3:0] ptr;
	logic       act;
	logic       rd;
	logic       sel;
	int         bitc;
	int         byten;

	initial begin
		sda_oe_out = 1'b0;
		act = 1'b0;
		rd = 1'b0;
		sel = 1'b0;
		bitc = 0;
		byten = 0;
		ptr = 4'h0;
		sh = 8'h00;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'h3C + 8'(i * 7);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start and repeated start restart the frame; stop ends it
	always @(negedge sda_in) begin
		if (scl_in === 1'b1) begin
			act = 1'b1;
			rd = 1'b0;
			bitc = 0;
			byten = 0;
		end
	end
	always @(posedge sda_in) begin
		if (scl_in === 1'b1) begin
			act = 1'b0;
			sda_oe_out = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A master not-acknowledge ends the read burst
	always @(posedge scl_in) begin
		if (act) begin
			if (bitc < 8) begin
				sh = {sh[6:0], sda_in};
			end else if (rd && sda_in) begin
				act = 1'b0;
			end
			bitc++;
		end
	end

	// Data changes only while the clock is low
	always @(negedge scl_in) begin
		if (act) begin
			if (bitc == 8) begin
				if (rd) begin
					sda_oe_out = 1'b0;
					ptr = ptr + 4'h1;
				end else begin
					if (byten == 0) begin
						sel = (sh[7:1] == DEV_ADDR);
						rd = sh[0] && sel;
					end else begin
						ptr = sh[3:0];
					end
					byten++;
					sda_oe_out = sel;
				end
			end else if (bitc == 9) begin
				bitc = 0;
				sda_oe_out = rd && !mem[ptr][7];
			end else begin
				sda_oe_out = rd && !mem[ptr][3'(7 - bitc)];
			end
		end
	end
endmodule

// ===== sim/rcl_loader_test.sv
// Self-checking bench for the redriver configuration loader
`include "rcl_regs.svh"
module rcl_loader_test;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LOAD_CYC = 300000;
	localparam real SCL_NS = 16.0 * `RCL_QUARTER_CYC;

	logic                  ref_clk = 1'b0;
	logic                  lclk = 1'b0;
	logic                  rstn = 1'b0;
	logic                  rd_n = 1'b1;
	logic                  hv = 1'b0;
	rcl_pkg::rcl_hwr_type  hw = '0;
	rcl_pkg::rcl_strap_type strap;
	rcl_pkg::rcl_cfg_type  cfg;
	rcl_pkg::rcl_mode_type mode;
	logic                  done_n;
	logic                  scl_oe;
	logic                  sda_oe;
	logic                  ee_oe;
	logic                  hrdy;
	logic                  scl_o;
	logic                  sda_o;
	int                    bad_count = 0;
	int                    check_count = 0;
	// Pull-ups on both wires; a driven pin shows the drive level
	wire scl = scl_oe ? scl_o : 1'b1;
	wire sda = (sda_oe ? sda_o : 1'b1) && !ee_oe;

	always #2 ref_clk = !ref_clk;
	always #7.5 lclk = !lclk;

	rcl_loader #(.LOAD_TIME_CYC(LOAD_CYC)) uut (
		.ref_clk_in(ref_clk), .resetn_in(rstn), .link_clk_in(lclk),
		.strap_in(strap), .read_en_n_in(rd_n), .done_n_out(done_n),
		.scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.host_wr_valid_in(hv), .host_wr_in(hw),
		.host_wr_ready_out(hrdy), .cfg_out(cfg), .mode_out(mode));
	rcl_eeprom_model ee (.scl_in(scl), .sda_in(sda), .sda_oe_out(ee_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] exp,
			input logic [127:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tmo(input string nm);
		bad_count++;
		$display("[ERR] %s expected event seen timeout", nm);
		complete_run();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wt_scl(input logic lv);
		int i;
		for (i = 0; i < 5000 && scl !== lv; i++) @(posedge ref_clk);
		if (i >= 5000) tmo("scl");
	endtask
	// Request held until ready is seen high at a falling link edge
	task automatic hwrite(input logic [3:0] a, input logic [7:0] d);
		logic r;
		int   i;
		r = 1'b0;
		@(posedge lclk);
		hw <= {a, d};
		hv <= 1'b1;
		for (i = 0; i < 50 && r !== 1'b1; i++) begin
			@(negedge lclk);
			r = hrdy;
			@(posedge lclk);
		end
		hv <= 1'b0;
		if (r !== 1'b1) tmo("take");
		repeat (2) @(posedge lclk);
		for (i = 0; i < 50 && hrdy !== 1'b1; i++) @(posedge lclk);
		if (i >= 50) tmo("ready");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_pin;
		logic any;
		any = 1'b0;
		cyc(20);
		chk("mode", rcl_pkg::RCL_MODE_PIN, mode);
		chk("cfg_pin", 128'hE4D8, cfg);
		repeat (400) begin
			@(posedge ref_clk);
			any = any | scl_oe | sda_oe;
		end
		chk("bus_oe", 1'b0, any);
		strap <= 16'h0000;
		cyc(20);
		chk("cfg_held", 128'hE4D8, cfg);
	endtask
	task automatic t_slave;
		strap.mode <= 2'h2;
		cyc(10);
		chk("mode", rcl_pkg::RCL_MODE_SLAVE, mode);
		hwrite(4'h5, 8'h5A);
		cyc(10);
		chk("cfg5", 8'h5A, cfg[5]);
		chk("done_slave", 1'b1, done_n);
	endtask
	task automatic t_master;
		realtime t1;
		realtime t2;
		int      n;
		logic [127:0] exp;
		strap.mode <= 2'h1;
		cyc(2000);
		chk("no_request", 2'b10, {done_n, scl_oe});
		rd_n <= 1'b0;
		wt_scl(1'b0);
		wt_scl(1'b1);
		t1 = $realtime;
		wt_scl(1'b0);
		wt_scl(1'b1);
		t2 = $realtime;
		chk("scl_period", 1'b1, (t2 - t1) >= SCL_NS - 8.0
			&& (t2 - t1) <= SCL_NS + 8.0);
		hwrite(4'hF, 8'hC3);
		chk("cfg_during", 8'hC3, cfg[15]);
		for (n = 0; n < LOAD_CYC && done_n !== 1'b0; n++) cyc(1);
		if (n >= LOAD_CYC) tmo("done");
		for (int i = 0; i < 16; i++) begin
			exp[i*8 +: 8] = 8'h3C + 8'(i * 7);
		end
		chk("cfg_loaded", exp, cfg);
		rd_n <= 1'b1;
		cyc(50);
		chk("done_stands", 1'b0, done_n);
		strap.mode <= 2'h0;
		cyc(20);
		chk("done_clear", 1'b1, done_n);
	endtask

	initial begin
		strap = 16'hD8E4;
		cyc(8);
		chk("reset_done", 1'b1, done_n);
		chk("reset_cfg", 128'h0, cfg);
		rstn <= 1'b1;
		// Host stays silent through the whole pin scenario
		t_pin();
		t_slave();
		t_master();
		complete_run();
	end
endmodule
